//--- inc/charger_regs_pkg.sv
package charger_regs_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_EVENT_FLAGS_FIRST = 8'hA3;
   localparam logic [7:0] ADDR_EVENT_FLAGS_SECOND = 8'hA4;
   localparam logic [7:0] ADDR_INT_ENABLE_FIRST = 8'hB3;
   localparam logic [7:0] ADDR_INT_ENABLE_SECOND = 8'hB4;
   localparam logic [7:0] ADDR_CHARGER_CONTROL = 8'hB6;
   localparam logic [7:0] ADDR_CHARGER_STATUS = 8'hB7;

   // Reset values
   localparam logic [7:0] RESET_EVENT_FLAGS = 8'h00;
   localparam logic [7:0] RESET_INT_ENABLE = 8'h00;
   localparam logic [7:0] RESET_CHARGER_CONTROL = 8'hC0;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Implemented bits of the flag and enable registers
   localparam logic [7:0] FIRST_FLAG_MASK = 8'hCC;
   localparam logic [7:0] SECOND_FLAG_MASK = 8'h2A;
   localparam logic [7:0] FIRST_ENABLE_MASK = 8'hCC;
   localparam logic [7:0] SECOND_ENABLE_MASK = 8'hEA;

   // Bit positions in the first flag register
   localparam int unsigned BIT_PIN_ONE_RISE = 7;
   localparam int unsigned BIT_PIN_ONE_FALL = 6;
   localparam int unsigned BIT_REMOTE_WAKE = 3;
   localparam int unsigned BIT_DISCONNECT = 2;

   // Bit positions in the second enable register; bits 5, 3 and 1 also in the second flag register
   localparam int unsigned BIT_INT_OVERRIDE_EN = 7;
   localparam int unsigned BIT_INT_OVERRIDE_VALUE = 6;
   localparam int unsigned BIT_CHARGER_FOUND = 5;
   localparam int unsigned BIT_ATTACH = 3;
   localparam int unsigned BIT_OVERVOLTAGE = 1;

   // Status register layout
   localparam int unsigned STATUS_KIND_LSB = 4;
   localparam int unsigned STATUS_ADVERT_LSB = 0;

   // Default charger behaviour codes
   localparam logic [1:0] BEHAVIOUR_NONE = 2'h0;
   localparam logic [1:0] BEHAVIOUR_DETECT = 2'h1;
   localparam logic [1:0] BEHAVIOUR_SHORT = 2'h2;
   localparam logic [1:0] BEHAVIOUR_AUTO = 2'h3;

   // Auto advertisement state codes
   localparam logic [2:0] ADVERT_NONE = 3'h0;
   localparam logic [2:0] ADVERT_PROFILE_THREE = 3'h5;
   localparam logic [2:0] ADVERT_LOW_VOLT = 3'h6;
   localparam logic [2:0] ADVERT_PLAIN = 3'h7;

   // Timing
   localparam longint unsigned CLK_HZ = 50_000_000;
   localparam longint unsigned LOW_VOLT_HOLD_S = 12;
   localparam longint unsigned PROFILE_HOLD_MS = 1000;
   localparam int unsigned LOW_VOLT_HOLD_CYCLES = 32'(LOW_VOLT_HOLD_S * CLK_HZ);
   localparam int unsigned PROFILE_HOLD_CYCLES = 32'(PROFILE_HOLD_MS * (CLK_HZ / 1000));

   // Charger control register, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] drive;
      logic [1:0] behaviour;
      logic bus_power_pol;
      logic low_volt_dis;
      logic pin_two_fn;
      logic found_pol;
   } charger_ctrl_t;

   // Advertisement sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_PROFILE = 4'h2,
      ST_LOW_VOLT = 4'h4,
      ST_PLAIN = 4'h8
   } advert_state_t;

endpackage

//--- hdl/advert_sequencer.sv
`timescale 1ns/100ps
module advert_sequencer #(
   parameter int unsigned PROFILE_HOLD_CYCLES = charger_regs_pkg::PROFILE_HOLD_CYCLES,
   parameter int unsigned LOW_VOLT_HOLD_CYCLES = charger_regs_pkg::LOW_VOLT_HOLD_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [1:0] i_behaviour,
   input wire logic i_low_volt_dis,
   output logic [2:0] o_advert_state,
   output logic o_low_volt_advert_mode
);

   charger_regs_pkg::advert_state_t state;
   charger_regs_pkg::advert_state_t next_state;
   logic [31:0] count;
   logic [1:0] behaviour_prev;
   logic [2:0] next_code;

   // Mode change restarts the sequence
   wire mode_changed = (i_behaviour != behaviour_prev);
   wire short_mode = (i_behaviour == charger_regs_pkg::BEHAVIOUR_SHORT);
   wire auto_mode = (i_behaviour == charger_regs_pkg::BEHAVIOUR_AUTO);
   wire profile_done = (count >= PROFILE_HOLD_CYCLES - 32'd1);
   wire low_volt_done = (count >= LOW_VOLT_HOLD_CYCLES - 32'd1);

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         charger_regs_pkg::ST_IDLE: begin
            if (auto_mode) begin
               next_state = charger_regs_pkg::ST_PROFILE;
            end else if (short_mode) begin
               next_state = i_low_volt_dis ? charger_regs_pkg::ST_PLAIN : charger_regs_pkg::ST_LOW_VOLT;
            end
         end
         charger_regs_pkg::ST_PROFILE: begin
            if (profile_done) begin
               next_state = i_low_volt_dis ? charger_regs_pkg::ST_PLAIN : charger_regs_pkg::ST_LOW_VOLT;
            end
         end
         charger_regs_pkg::ST_LOW_VOLT: begin
            if (i_low_volt_dis) begin
               next_state = charger_regs_pkg::ST_PLAIN;
            end else if (auto_mode && low_volt_done) begin
               next_state = charger_regs_pkg::ST_PLAIN;
            end
         end
         charger_regs_pkg::ST_PLAIN: begin
            if (short_mode && !i_low_volt_dis) begin
               next_state = charger_regs_pkg::ST_LOW_VOLT;
            end
         end
         default: begin
            next_state = charger_regs_pkg::ST_IDLE;
         end
      endcase
      if (mode_changed || !(short_mode || auto_mode)) begin
         next_state = charger_regs_pkg::ST_IDLE;
      end
   end

   // Code shown for each state
   always_comb begin
      case (next_state)
         charger_regs_pkg::ST_PROFILE: next_code = charger_regs_pkg::ADVERT_PROFILE_THREE;
         charger_regs_pkg::ST_LOW_VOLT: next_code = charger_regs_pkg::ADVERT_LOW_VOLT;
         charger_regs_pkg::ST_PLAIN: next_code = charger_regs_pkg::ADVERT_PLAIN;
         default: next_code = charger_regs_pkg::ADVERT_NONE;
      endcase
   end

   // State, hold counter and registered outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= charger_regs_pkg::ST_IDLE;
         count <= 32'h0;
         behaviour_prev <= charger_regs_pkg::BEHAVIOUR_NONE;
         o_advert_state <= charger_regs_pkg::ADVERT_NONE;
         o_low_volt_advert_mode <= 1'b0;
      end else begin
         state <= next_state;
         count <= (next_state != state) ? 32'h0 : count + 32'd1;
         behaviour_prev <= i_behaviour;
         o_advert_state <= next_code;
         o_low_volt_advert_mode <= (next_state == charger_regs_pkg::ST_LOW_VOLT);
      end
   end

endmodule

//--- hdl/charger_and_interrupt_regs.sv
`timescale 1ns/100ps
module charger_and_interrupt_regs #(
   parameter int unsigned PROFILE_HOLD_CYCLES = charger_regs_pkg::PROFILE_HOLD_CYCLES,
   parameter int unsigned LOW_VOLT_HOLD_CYCLES = charger_regs_pkg::LOW_VOLT_HOLD_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_general_pin_one,
   input wire logic i_remote_wake_event,
   input wire logic i_disconnect_event,
   input wire logic i_charger_found_event,
   input wire logic i_attach_event,
   input wire logic i_overvoltage_event,
   input wire logic i_charger_present,
   input wire logic [2:0] i_detected_charger_kind,
   input wire logic i_bus_power_request,
   output logic [1:0] o_serial_drive_strength,
   output logic o_detect_start,
   output logic [2:0] o_advert_state,
   output logic o_low_volt_advert_mode,
   output logic o_bus_power_ctrl,
   output logic o_charger_found_output,
   output logic o_general_pin_two
);

   charger_regs_pkg::charger_ctrl_t ctrl;
   logic [7:0] flags_first;
   logic [7:0] flags_second;
   logic [7:0] enable_first;
   logic [7:0] enable_second;
   logic pin_one_meta;
   logic pin_one_sync;
   logic pin_one_prev;
   logic [7:0] next_flags_first;
   logic [7:0] next_flags_second;

   // Write and read decode
   wire hit_flags_first = (i_reg_addr == charger_regs_pkg::ADDR_EVENT_FLAGS_FIRST);
   wire hit_flags_second = (i_reg_addr == charger_regs_pkg::ADDR_EVENT_FLAGS_SECOND);
   wire hit_enable_first = (i_reg_addr == charger_regs_pkg::ADDR_INT_ENABLE_FIRST);
   wire hit_enable_second = (i_reg_addr == charger_regs_pkg::ADDR_INT_ENABLE_SECOND);
   wire hit_control = (i_reg_addr == charger_regs_pkg::ADDR_CHARGER_CONTROL);
   wire hit_status = (i_reg_addr == charger_regs_pkg::ADDR_CHARGER_STATUS);
   wire [7:0] clear_first = (i_reg_wr && hit_flags_first) ? i_reg_wdata : 8'h00;
   wire [7:0] clear_second = (i_reg_wr && hit_flags_second) ? i_reg_wdata : 8'h00;

   // Pin one edges after the synchroniser
   wire pin_one_rise = pin_one_sync & ~pin_one_prev;
   wire pin_one_fall = ~pin_one_sync & pin_one_prev;

   // Raw events placed at their flag positions
   wire [7:0] events_first = {
      pin_one_rise,
      pin_one_fall,
      2'b00,
      i_remote_wake_event,
      i_disconnect_event,
      2'b00
   };
   wire [7:0] events_second = {
      2'b00,
      i_charger_found_event,
      1'b0,
      i_attach_event,
      1'b0,
      i_overvoltage_event,
      1'b0
   };

   // Only enabled events latch
   wire [7:0] set_first = events_first & enable_first & charger_regs_pkg::FIRST_FLAG_MASK;
   wire [7:0] set_second = events_second & enable_second & charger_regs_pkg::SECOND_FLAG_MASK;

   // Per-bit sticky flags, set wins over a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
         assign next_flags_first[gi] = set_first[gi] | (flags_first[gi] & ~clear_first[gi]);
         assign next_flags_second[gi] = set_second[gi] | (flags_second[gi] & ~clear_second[gi]);
      end
   endgenerate

   // Pending interrupt and pin two source
   wire int_pending = |(flags_first & enable_first) | |(flags_second & enable_second);
   wire override_en = enable_second[charger_regs_pkg::BIT_INT_OVERRIDE_EN];
   wire override_value = enable_second[charger_regs_pkg::BIT_INT_OVERRIDE_VALUE];
   wire int_asserted = override_en ? override_value : int_pending;
   wire found_level = ctrl.found_pol ? i_charger_present : ~i_charger_present;
   wire next_pin_two = ctrl.pin_two_fn ? found_level : ~int_asserted;

   // Status register contents
   wire [7:0] status_word = {1'b0, i_detected_charger_kind, 1'b0, o_advert_state};

   // Read data selection
   wire [7:0] read_mux =
      hit_flags_first ? flags_first :
      hit_flags_second ? flags_second :
      hit_enable_first ? enable_first :
      hit_enable_second ? enable_second :
      hit_control ? ctrl :
      hit_status ? status_word :
      charger_regs_pkg::READ_UNMAPPED;

   // Detection starts on pin-one rise in detect mode
   wire next_detect_start = (ctrl.behaviour == charger_regs_pkg::BEHAVIOUR_DETECT) && pin_one_rise;

   // Two-flop synchroniser and edge history for pin one
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pin_one_meta <= 1'b0;
         pin_one_sync <= 1'b0;
         pin_one_prev <= 1'b0;
      end else begin
         pin_one_meta <= i_general_pin_one;
         pin_one_sync <= pin_one_meta;
         pin_one_prev <= pin_one_sync;
      end
   end

   // Charger control register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ctrl <= charger_regs_pkg::RESET_CHARGER_CONTROL;
      end else if (i_reg_wr && hit_control) begin
         ctrl <= i_reg_wdata;
      end
   end

   // Interrupt enable registers
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         enable_first <= charger_regs_pkg::RESET_INT_ENABLE;
         enable_second <= charger_regs_pkg::RESET_INT_ENABLE;
      end else begin
         if (i_reg_wr && hit_enable_first) begin
            enable_first <= i_reg_wdata & charger_regs_pkg::FIRST_ENABLE_MASK;
         end
         if (i_reg_wr && hit_enable_second) begin
            enable_second <= i_reg_wdata & charger_regs_pkg::SECOND_ENABLE_MASK;
         end
      end
   end

   // Sticky event flags
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         flags_first <= charger_regs_pkg::RESET_EVENT_FLAGS;
         flags_second <= charger_regs_pkg::RESET_EVENT_FLAGS;
      end else begin
         flags_first <= next_flags_first;
         flags_second <= next_flags_second;
      end
   end

   // Read answer, one cycle after the strobe
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_reg_rdata <= charger_regs_pkg::READ_UNMAPPED;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rdata <= i_reg_rd ? read_mux : o_reg_rdata;
         o_reg_rvalid <= i_reg_rd;
      end
   end

   // Registered pin outputs
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_serial_drive_strength <= charger_regs_pkg::RESET_CHARGER_CONTROL[7:6];
         o_detect_start <= 1'b0;
         o_bus_power_ctrl <= 1'b0;
         o_charger_found_output <= 1'b1;
         o_general_pin_two <= 1'b1;
      end else begin
         o_serial_drive_strength <= ctrl.drive;
         o_detect_start <= next_detect_start;
         o_bus_power_ctrl <= i_bus_power_request ^ ctrl.bus_power_pol;
         o_charger_found_output <= found_level;
         o_general_pin_two <= next_pin_two;
      end
   end

   // Default-state advertisement sequence
   advert_sequencer #(
      .PROFILE_HOLD_CYCLES(PROFILE_HOLD_CYCLES),
      .LOW_VOLT_HOLD_CYCLES(LOW_VOLT_HOLD_CYCLES)
   ) u_advert (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_behaviour(ctrl.behaviour),
      .i_low_volt_dis(ctrl.low_volt_dis),
      .o_advert_state(o_advert_state),
      .o_low_volt_advert_mode(o_low_volt_advert_mode)
   );

endmodule

//--- testbench/charger_regs_checker.sv
`timescale 1ns/100ps
module charger_regs_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_charger_present,
   input wire logic [2:0] i_detected_charger_kind,
   input wire logic i_bus_power_request,
   input wire logic [1:0] o_serial_drive_strength,
   input wire logic [2:0] o_advert_state,
   input wire logic o_low_volt_advert_mode,
   input wire logic o_bus_power_ctrl,
   input wire logic o_charger_found_output,
   input wire logic o_general_pin_two
);
   logic [7:0] ctrl;
   wire ctl_wr = i_reg_wr && i_reg_addr == 8'hB6;
   wire st_rd = i_reg_rd && i_reg_addr == 8'hB7;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Shadow of the control register
   always_ff @(posedge i_ref_clk) begin
      if (i_rst)
         ctrl <= 8'hC0;
      else if (ctl_wr)
         ctrl <= i_reg_wdata;
   end
   sequence short_on;
      ctl_wr && i_reg_wdata[5:4] == 2'h2 && !i_reg_wdata[2];
   endsequence
   sequence short_off;
      ctl_wr && i_reg_wdata[5:4] == 2'h2 && i_reg_wdata[2];
   endsequence
   rvalid_pulse_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   rvalid_quiet_a: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("stray read answer");
   // Drive pins follow the control register one edge after it changes
   drive_follow_a: assert property (ctl_wr |-> ##2 o_serial_drive_strength == $past(i_reg_wdata[7:6], 2))
      else $error("drive strength wrong");
   status_read_a: assert property (st_rd |=> o_reg_rdata ==
      {1'b0, $past(i_detected_charger_kind), 1'b0, $past(o_advert_state)}) else $error("status wrong");
   advert_code_a: assert property (!(o_advert_state inside {3'h1, 3'h2, 3'h3, 3'h4}))
      else $error("bad advert code");
   low_volt_a: assert property (o_low_volt_advert_mode == (o_advert_state == 3'h6))
      else $error("low volt mode wrong");
   bus_power_a: assert property (!$past(i_rst) |-> o_bus_power_ctrl == $past(i_bus_power_request ^ ctrl[3]))
      else $error("bus power polarity wrong");
   found_pol_a: assert property (!$past(i_rst) |-> o_charger_found_output == $past(i_charger_present ~^ ctrl[0]))
      else $error("found polarity wrong");
   pin_two_fn_a: assert property (!$past(i_rst) && $past(ctrl[1]) |-> o_general_pin_two == o_charger_found_output)
      else $error("pin two function wrong");
   short_on_a: assert property (short_on |-> ##[1:4] o_advert_state == 3'h6) else $error("no low volt");
   short_off_a: assert property (short_off |-> ##[1:4] o_advert_state == 3'h7) else $error("no plain");
endmodule
bind charger_and_interrupt_regs charger_regs_checker chk (.i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_charger_present, .i_detected_charger_kind,
   .i_bus_power_request, .o_serial_drive_strength, .o_advert_state, .o_low_volt_advert_mode,
   .o_bus_power_ctrl, .o_charger_found_output, .o_general_pin_two);

//--- testbench/host_port_model.sv
`timescale 1ns/100ps
module host_port_model (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output logic [7:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   // Idle port at time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   // One write strobe; lines scrambled once released
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   // One read strobe; data taken with the answer pulse
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_ref_clk);
      #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
   endtask
endmodule

//--- testbench/charger_and_interrupt_regs_tb.sv
`timescale 1ns/100ps
module charger_and_interrupt_regs_tb;
   logic i_ref_clk;
   logic i_rst;
   logic [7:0] i_reg_addr;
   logic [7:0] i_reg_wdata;
   logic i_reg_wr;
   logic i_reg_rd;
   logic [7:0] o_reg_rdata;
   logic o_reg_rvalid;
   logic i_general_pin_one;
   logic [4:0] ev;
   logic i_charger_present;
   logic [2:0] i_detected_charger_kind;
   logic i_bus_power_request;
   logic [1:0] o_serial_drive_strength;
   logic o_detect_start;
   logic [2:0] o_advert_state;
   logic o_low_volt_advert_mode;
   logic o_bus_power_ctrl;
   logic o_charger_found_output;
   logic o_general_pin_two;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   localparam int unsigned PROF = 10;
   localparam int unsigned LOWV = 20;
   localparam logic [7:0] FL_ADDR [5] = '{8'hA3, 8'hA3, 8'hA4, 8'hA4, 8'hA4};
   localparam logic [7:0] FL_BIT [5] = '{8'h08, 8'h04, 8'h20, 8'h08, 8'h02};
   charger_and_interrupt_regs #(.PROFILE_HOLD_CYCLES(PROF), .LOW_VOLT_HOLD_CYCLES(LOWV)) DUT (
      .i_ref_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
      .i_general_pin_one, .i_remote_wake_event(ev[0]), .i_disconnect_event(ev[1]),
      .i_charger_found_event(ev[2]), .i_attach_event(ev[3]), .i_overvoltage_event(ev[4]),
      .i_charger_present, .i_detected_charger_kind, .i_bus_power_request, .o_serial_drive_strength,
      .o_detect_start, .o_advert_state, .o_low_volt_advert_mode, .o_bus_power_ctrl,
      .o_charger_found_output, .o_general_pin_two);
   host_port_model host (.i_ref_clk, .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid), .o_addr(i_reg_addr),
      .o_wdata(i_reg_wdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd));
   // Clock
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end
   // Hang guard
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(a, d);
      check(d, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic pulse(input int i);
      tick(1);
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
   endtask
   task automatic t_reset();
      rd_chk(8'hA3, 8'h00);
      rd_chk(8'hA4, 8'h00);
      rd_chk(8'hB6, 8'hC0);
      rd_chk(8'h10, 8'h00);
      check({6'h0, o_serial_drive_strength}, 8'h03);
      $display("test reset finished");
   endtask
   task automatic t_control();
      host.write_reg(8'hB6, 8'h4B);
      rd_chk(8'hB6, 8'h4B);
      check({6'h0, o_serial_drive_strength}, 8'h01);
      i_bus_power_request = 1'b1;
      i_charger_present = 1'b1;
      tick(2);
      check({7'h0, o_bus_power_ctrl}, 8'h00);
      check({7'h0, o_charger_found_output}, 8'h01);
      check({7'h0, o_general_pin_two}, 8'h01);
      i_charger_present = 1'b0;
      tick(2);
      check({7'h0, o_general_pin_two}, 8'h00);
      host.write_reg(8'hB7, 8'hFF);
      rd_chk(8'hB7, 8'h00);
      host.write_reg(8'hB6, 8'hC0);
      i_bus_power_request = 1'b0;
      $display("test control finished");
   endtask
   task automatic t_kinds();
      for (int k = 0; k < 8; k++) begin
         i_detected_charger_kind = 3'(k);
         rd_chk(8'hB7, {1'b0, 3'(k), 4'h0});
      end
      i_detected_charger_kind = 3'h0;
      $display("test kinds finished");
   endtask
   task automatic t_flags();
      host.write_reg(8'hB3, 8'hCC);
      host.write_reg(8'hB4, 8'h2A);
      i_general_pin_one = 1'b1;
      tick(5);
      rd_chk(8'hA3, 8'h80);
      check({7'h0, o_general_pin_two}, 8'h00);
      i_general_pin_one = 1'b0;
      tick(5);
      rd_chk(8'hA3, 8'hC0);
      host.write_reg(8'hA3, 8'hC0);
      tick(2);
      check({7'h0, o_general_pin_two}, 8'h01);
      for (int i = 0; i < 5; i++) begin
         pulse(i);
         rd_chk(FL_ADDR[i], FL_BIT[i]);
         check({7'h0, o_general_pin_two}, 8'h00);
         host.write_reg(FL_ADDR[i], FL_BIT[i]);
         rd_chk(FL_ADDR[i], 8'h00);
      end
      host.write_reg(8'hB4, 8'h28);
      pulse(4);
      rd_chk(8'hA4, 8'h00);
      host.write_reg(8'hB4, 8'h2A);
      rd_chk(8'hA4, 8'h00);
      $display("test flags finished");
   endtask
   task automatic t_override();
      host.write_reg(8'hB4, 8'hC0);
      tick(2);
      check({7'h0, o_general_pin_two}, 8'h00);
      host.write_reg(8'hB4, 8'h80);
      tick(2);
      check({7'h0, o_general_pin_two}, 8'h01);
      host.write_reg(8'hB4, 8'h00);
      $display("test override finished");
   endtask
   task automatic t_detect();
      int n;
      n = 0;
      host.write_reg(8'hB6, 8'hD0);
      i_general_pin_one = 1'b1;
      repeat (10) begin
         tick(1);
         n += (o_detect_start === 1'b1);
      end
      check(8'(n), 8'h01);
      i_general_pin_one = 1'b0;
      $display("test detect finished");
   endtask
   task automatic adv_run(input logic [7:0] ctl, input int e5, input int e6, input logic [2:0] efin);
      int n5;
      int n6;
      n5 = 0;
      n6 = 0;
      host.write_reg(8'hB6, 8'hC0);
      tick(3);
      host.write_reg(8'hB6, ctl);
      repeat (60) begin
         tick(1);
         n5 += (o_advert_state === 3'h5);
         n6 += (o_advert_state === 3'h6);
      end
      check(8'(n5), 8'(e5));
      if (e6 >= 0)
         check(8'(n6), 8'(e6));
      check({5'h0, o_advert_state}, {5'h0, efin});
      $display("test advert %h finished", ctl);
   endtask
   // Main sequence
   initial begin
      i_rst = 1'b1;
      ev = 5'h00;
      i_general_pin_one = 1'b0;
      i_charger_present = 1'b0;
      i_detected_charger_kind = 3'h0;
      i_bus_power_request = 1'b0;
      repeat (16) @(posedge i_ref_clk);
      #1;
      i_rst = 1'b0;
      t_reset();
      t_control();
      t_kinds();
      t_flags();
      t_override();
      t_detect();
      adv_run(8'h30, PROF, LOWV, 3'h7);
      adv_run(8'h34, PROF, 0, 3'h7);
      adv_run(8'h20, 0, -1, 3'h6);
      adv_run(8'h24, 0, 0, 3'h7);
      adv_run(8'h10, 0, 0, 3'h0);
      final_report();
   end
endmodule
